/* plsl_cfg.svh */
// Register map, field positions, reset values and timing counts of the link control block
`ifndef PLSL_CFG_SVH
`define PLSL_CFG_SVH
// ==========================================
// Register offsets
`define PLSL_OFS_ENABLE 8'h01
`define PLSL_OFS_LDO 8'h02
`define PLSL_OFS_TIMER 8'h03
`define PLSL_OFS_ACTION 8'h04
`define PLSL_OFS_STATUS 8'h05
`define PLSL_OFS_DEV_FLAGS 8'h07
`define PLSL_OFS_DEV_MASK 8'h08
`define PLSL_OFS_COMM 8'h09
`define PLSL_OFS_LINK_FLAGS 8'h0b
`define PLSL_OFS_LINK_MASK 8'h0c
`define PLSL_OFS_TX0 8'h0d
`define PLSL_OFS_TX1 8'h0e
`define PLSL_OFS_TX2 8'h0f
`define PLSL_OFS_RX0 8'h10
`define PLSL_OFS_RX1 8'h11
`define PLSL_OFS_RX2 8'h12
// ==========================================
// Field positions
`define PLSL_BIT_ENABLE 0
`define PLSL_BIT_RANGE 0
`define PLSL_BIT_RESTART 2
`define PLSL_BIT_FORCE_IDLE 3
`define PLSL_BIT_ADDR 0
`define PLSL_BIT_STATE_CHG 0
`define PLSL_BIT_SUMMARY 3
`define PLSL_BIT_THERMAL 5
`define PLSL_BIT_RX_DET 0
`define PLSL_BIT_NEW_B 1
`define PLSL_BIT_NEW_A 2
`define PLSL_BIT_RX_ERR 3
`define PLSL_BIT_TX_OK 5
`define PLSL_BIT_TX_ERR 6
// ==========================================
// Reset values
`define PLSL_RST_BYTE 8'h00
`define PLSL_RST_LDO 8'h04
`define PLSL_RST_COMM 8'h00
// ==========================================
// Timing
`define PLSL_CLK_MHZ 200
`define PLSL_SHORT_BLANK_US 10
`define PLSL_SHORT_BLANK_CYC (`PLSL_SHORT_BLANK_US * `PLSL_CLK_MHZ)
`define PLSL_CHG_STAT_OFF 2'b00
`define PLSL_CHG_STAT_RUN 2'b01
`define PLSL_CHG_STAT_DONE 2'b10
`endif

/* plsl_pkg.sv */
// Types and shared checksum arithmetic of the link control block
package plsl_pkg;
   // ==========================================
   // Combined master and slave state machine
   typedef enum logic [2:0] {
      PLSL_SHUTDOWN,
      PLSL_DETECT,
      PLSL_FOUND,
      PLSL_LINK_BUSY,
      PLSL_SAFE,
      PLSL_IDLE
   } plsl_state_e;

   // Modulo-256 sum of the first n data bytes
   function automatic logic [7:0] plsl_csum(input logic [7:0] b0, input logic [7:0] b1,
                                            input logic [7:0] b2, input logic [1:0] n);
      logic [7:0] s;
      s = b0;
      if (n >= 2'd2) begin
         s = s + b1;
      end
      if (n == 2'd3) begin
         s = s + b2;
      end
      return s;
   endfunction : plsl_csum
endpackage : plsl_pkg

/* plsl_link_ctrl.sv */
// Power line link control: state machine, packet receive and send, timers, flags
`timescale 1ns/100ps
`include "plsl_cfg.svh"

module plsl_link_ctrl
   import plsl_pkg::*;
#(
   parameter int CHG_UNIT_CYCLES = 200_000
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic enable_pin_n,
   input wire logic line_below_short,
   input wire logic line_above_detect,
   input wire logic thermal_hot,
   input wire logic role_master_pin,
   input wire logic slave_address_pin,
   input wire logic rx_start,
   input wire logic rx_valid,
   input wire logic [7:0] rx_byte,
   input wire logic rx_end,
   input wire logic rx_error,
   output logic tx_valid,
   output logic [7:0] tx_byte,
   output logic tx_last,
   input wire logic tx_ready,
   output logic int_n,
   output logic pullup_on,
   output logic switch_closed,
   output logic link_enabled,
   output logic ldo_bypass,
   output logic ldo_fixed,
   output logic [2:0] ldo_offset,
   output logic [2:0] ldo_min
);
   localparam int BLANK_CYC = `PLSL_SHORT_BLANK_CYC;

   // ==========================================
   // Pin synchronisers
   logic [5:0] pin_s1;
   logic [5:0] pin_s2;
   logic en_off;
   logic below_s;
   logic above_s;
   logic hot_s;
   logic is_master;
   logic addr_s;
   logic hot_d;

   // First stage feeds only the second stage; kept out of reset so the
   // pins flush through during reset and no false level follows release
   always_ff @(posedge sys_clk) begin
      pin_s1 <= {enable_pin_n, line_below_short, line_above_detect,
                 thermal_hot, role_master_pin, slave_address_pin};
      pin_s2 <= pin_s1;
   end

   // Previous thermal level for the flag's edge detector
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         hot_d <= 1'b0;
      end else begin
         hot_d <= hot_s;
      end
   end
   assign en_off = pin_s2[5];
   assign below_s = pin_s2[4];
   assign above_s = pin_s2[3];
   assign hot_s = pin_s2[2];
   assign is_master = pin_s2[1];
   assign addr_s = pin_s2[0];

   // ==========================================
   // Register state
   plsl_state_e state, next_state;
   logic enable_bit, next_enable_bit;
   logic [7:0] ldo_reg, next_ldo_reg;
   logic [7:0] timer_reg, next_timer_reg;
   logic [7:0] comm, next_comm;
   logic [7:0] dev_flags, next_dev_flags;
   logic [7:0] dev_mask, next_dev_mask;
   logic [7:0] link_flags, next_link_flags;
   logic [7:0] link_mask, next_link_mask;
   logic [7:0] tx_data [3];
   logic [7:0] next_tx_data [3];
   logic [7:0] rx_data [3];
   logic [7:0] next_rx_data [3];
   logic [7:0] rx_buf [4];
   logic [7:0] next_rx_buf [4];
   logic [2:0] rx_cnt, next_rx_cnt;
   logic rx_seen, next_rx_seen;
   logic [1:0] tx_idx, next_tx_idx;
   logic next_tx_valid, next_tx_last;
   logic [7:0] next_tx_byte;
   logic [15:0] blank_cnt, next_blank_cnt;
   logic [31:0] chg_cnt, next_chg_cnt;
   logic [1:0] chg_stat, next_chg_stat;
   logic [7:0] next_reg_rdata;
   logic next_int_n;
   logic next_pullup_on, next_switch_closed, next_link_enabled;
   logic disabled;
   logic wr_comm;
   logic [7:0] link_live;

   // Enable is off only while the pin is high and the bit is clear
   assign disabled = en_off & ~enable_bit;
   assign wr_comm = reg_wr && (reg_addr == `PLSL_OFS_COMM);

   // ==========================================
   // Next-state logic for everything but the power path, interrupt pin and regulator outputs
   always_comb begin
      logic [1:0] n_data;
      logic [2:0] chg_sel;
      logic [31:0] chg_lim;
      logic pkt_ok;
      n_data = 2'd0;
      chg_sel = 3'd0;
      chg_lim = 32'd0;
      pkt_ok = 1'b0;
      next_state = state;
      next_enable_bit = enable_bit;
      next_ldo_reg = ldo_reg;
      next_timer_reg = timer_reg;
      next_comm = comm;
      next_dev_flags = dev_flags;
      next_dev_mask = dev_mask;
      next_link_flags = link_flags;
      next_link_mask = link_mask;
      next_tx_data = tx_data;
      next_rx_data = rx_data;
      next_rx_buf = rx_buf;
      next_rx_cnt = rx_cnt;
      next_rx_seen = rx_seen;
      next_tx_idx = tx_idx;
      next_tx_valid = tx_valid;
      next_tx_last = tx_last;
      next_tx_byte = tx_byte;
      next_blank_cnt = blank_cnt;
      next_chg_cnt = chg_cnt;
      next_chg_stat = chg_stat;
      next_reg_rdata = reg_rdata;

      // Register writes; host must match speed and parity itself
      if (reg_wr) begin
         case (reg_addr)
            `PLSL_OFS_ENABLE: next_enable_bit = reg_wdata[`PLSL_BIT_ENABLE];
            `PLSL_OFS_LDO: next_ldo_reg = reg_wdata;
            `PLSL_OFS_TIMER: next_timer_reg = reg_wdata;
            `PLSL_OFS_DEV_MASK: next_dev_mask = reg_wdata;
            `PLSL_OFS_COMM: next_comm = reg_wdata;
            `PLSL_OFS_LINK_MASK: next_link_mask = reg_wdata;
            `PLSL_OFS_TX0: next_tx_data[0] = reg_wdata;
            `PLSL_OFS_TX1: next_tx_data[1] = reg_wdata;
            `PLSL_OFS_TX2: next_tx_data[2] = reg_wdata;
            default: ;
         endcase
      end

      // Reads return the live value; flag registers clear on read
      if (reg_rd) begin
         case (reg_addr)
            `PLSL_OFS_ENABLE: next_reg_rdata = {7'h00, enable_bit};
            `PLSL_OFS_LDO: next_reg_rdata = ldo_reg;
            `PLSL_OFS_TIMER: next_reg_rdata = timer_reg;
            `PLSL_OFS_STATUS: next_reg_rdata = {chg_stat, 1'b0, 3'(state), 1'b0, addr_s};
            `PLSL_OFS_DEV_FLAGS: next_reg_rdata = dev_flags;
            `PLSL_OFS_DEV_MASK: next_reg_rdata = dev_mask;
            `PLSL_OFS_COMM: next_reg_rdata = comm;
            `PLSL_OFS_LINK_FLAGS: next_reg_rdata = link_flags;
            `PLSL_OFS_LINK_MASK: next_reg_rdata = link_mask;
            `PLSL_OFS_TX0: next_reg_rdata = tx_data[0];
            `PLSL_OFS_TX1: next_reg_rdata = tx_data[1];
            `PLSL_OFS_TX2: next_reg_rdata = tx_data[2];
            `PLSL_OFS_RX0: next_reg_rdata = rx_data[0];
            `PLSL_OFS_RX1: next_reg_rdata = rx_data[1];
            `PLSL_OFS_RX2: next_reg_rdata = rx_data[2];
            default: next_reg_rdata = `PLSL_RST_BYTE;
         endcase
         if (reg_addr == `PLSL_OFS_DEV_FLAGS) begin
            next_dev_flags = `PLSL_RST_BYTE;
         end
         if (reg_addr == `PLSL_OFS_LINK_FLAGS) begin
            next_link_flags = `PLSL_RST_BYTE;
         end
      end

      // State machine; master and slave share the encoding
      case (state)
         PLSL_SHUTDOWN: begin
            if (!disabled) begin
               next_state = PLSL_DETECT;
            end
         end
         PLSL_DETECT: begin
            next_blank_cnt = 16'd0;
            if (is_master && below_s) begin
               next_state = PLSL_FOUND;
            end else if (!is_master && above_s) begin
               next_state = PLSL_FOUND;
            end
         end
         PLSL_FOUND: begin
            if (is_master) begin
               // Blanking counter stops once the line has come up
               if (!above_s && blank_cnt != 16'hffff) begin
                  next_blank_cnt = blank_cnt + 16'd1;
               end
               if (!above_s && blank_cnt >= 16'(BLANK_CYC - 1)) begin
                  next_state = PLSL_SAFE;
               end else if (tx_valid) begin
                  next_state = PLSL_LINK_BUSY;
               end
            end else if (reg_wr && reg_addr == `PLSL_OFS_ACTION &&
                         reg_wdata[`PLSL_BIT_FORCE_IDLE]) begin
               next_state = PLSL_IDLE;
            end
         end
         PLSL_LINK_BUSY: begin
            if (!tx_valid) begin
               next_state = PLSL_FOUND;
            end
         end
         PLSL_SAFE, PLSL_IDLE: ;
         default: next_state = PLSL_SHUTDOWN;
      endcase
      // No detach sensing: the restart bit sends any state but shutdown back to detection
      if (reg_wr && reg_addr == `PLSL_OFS_ACTION && reg_wdata[`PLSL_BIT_RESTART] &&
          state != PLSL_SHUTDOWN) begin
         next_state = PLSL_DETECT;
      end
      if (disabled) begin
         next_state = PLSL_SHUTDOWN;
      end
      // Thermal shutdown leaves the state machine alone
      if (hot_s && !hot_d) begin
         next_dev_flags[`PLSL_BIT_THERMAL] = 1'b1;
      end
      if (next_state != state) begin
         next_dev_flags[`PLSL_BIT_STATE_CHG] = 1'b1;
      end

      // Charge timer, period in units from the period field
      chg_sel = {1'b0, timer_reg[5:4]} + 3'd1;
      chg_lim = 32'(CHG_UNIT_CYCLES) * 32'(chg_sel);
      if (state == PLSL_FOUND || state == PLSL_LINK_BUSY) begin
         if (chg_cnt < chg_lim) begin
            next_chg_cnt = chg_cnt + 32'd1;
            next_chg_stat = `PLSL_CHG_STAT_RUN;
         end else begin
            next_chg_stat = `PLSL_CHG_STAT_DONE;
         end
      end else if (state == PLSL_DETECT || state == PLSL_SHUTDOWN) begin
         next_chg_cnt = 32'd0;
         next_chg_stat = `PLSL_CHG_STAT_OFF;
      end

      // Packet receive, only while the link is up
      if (link_enabled) begin
         if (rx_start) begin
            next_link_flags[`PLSL_BIT_RX_DET] = 1'b1;
            next_rx_cnt = 3'd0;
         end else if (rx_valid && rx_cnt != 3'd4) begin
            next_rx_buf[rx_cnt[1:0]] = rx_byte;
            next_rx_cnt = rx_cnt + 3'd1;
         end
         if (rx_end) begin
            // Last byte taken is the checksum; one to three data bytes before it
            n_data = 2'(rx_cnt - 3'd1);
            pkt_ok = !rx_error && rx_cnt >= 3'd2 && rx_cnt <= 3'd4 &&
                     plsl_csum(rx_buf[0], rx_buf[1], rx_buf[2], n_data) == rx_buf[n_data];
            if (pkt_ok) begin
               for (int i = 0; i < 3; i++) begin
                  next_rx_data[i] = (2'(i) < n_data) ? rx_buf[i] : `PLSL_RST_BYTE;
               end
               next_link_flags[`PLSL_BIT_NEW_A] = 1'b1;
               next_link_flags[`PLSL_BIT_NEW_B] = next_link_flags[`PLSL_BIT_NEW_B] |
                                                  (n_data >= 2'd2);
               next_rx_seen = 1'b1;
            end else begin
               next_link_flags[`PLSL_BIT_RX_ERR] = 1'b1;
            end
         end
      end

      // Send: the count field starts a response of data plus checksum
      if (tx_valid) begin
         if (tx_ready) begin
            if (tx_last) begin
               next_tx_valid = 1'b0;
               next_tx_last = 1'b0;
               next_comm[1:0] = 2'b00;
               next_link_flags[`PLSL_BIT_TX_OK] = 1'b1;
            end else begin
               next_tx_idx = tx_idx + 2'd1;
               if (next_tx_idx == comm[1:0]) begin
                  next_tx_last = 1'b1;
                  next_tx_byte = plsl_csum(tx_data[0], tx_data[1], tx_data[2], comm[1:0]);
               end else begin
                  next_tx_byte = tx_data[next_tx_idx];
               end
            end
         end
         next_comm[1:0] = tx_last && tx_ready ? 2'b00 : comm[1:0];
      end else if (wr_comm && reg_wdata[1:0] != 2'b00) begin
         // A slave may only answer a packet it has received
         if (link_enabled && (is_master || rx_seen)) begin
            next_tx_valid = 1'b1;
            next_tx_idx = 2'd0;
            next_tx_byte = tx_data[0];
            next_rx_seen = 1'b0;
         end else begin
            next_comm[1:0] = 2'b00;
            next_link_flags[`PLSL_BIT_TX_ERR] = 1'b1;
         end
      end
      if (!link_enabled && state != PLSL_LINK_BUSY) begin
         next_rx_seen = 1'b0;
      end

      // Summary flag follows the link flags it gathers
      next_dev_flags[`PLSL_BIT_SUMMARY] = |next_link_flags;
   end

   // Power path and interrupt pin; thermal overrides the line switch, not the pullup
   assign link_live = link_flags & link_mask;
   always_comb begin
      next_pullup_on = is_master && state == PLSL_DETECT;
      next_switch_closed = is_master && !hot_s &&
                           (next_state == PLSL_FOUND || next_state == PLSL_LINK_BUSY);
      next_link_enabled = next_state == PLSL_FOUND || next_state == PLSL_LINK_BUSY;
      // Masked flags stay readable but cannot pull the pin
      next_int_n = !(|(next_dev_flags & dev_mask &
                       ~(8'h01 << `PLSL_BIT_SUMMARY)) ||
                     (dev_mask[`PLSL_BIT_SUMMARY] && |(next_link_flags & link_mask)));
   end

   // ==========================================
   // Registers
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         state <= PLSL_SHUTDOWN;
         enable_bit <= 1'b0;
         ldo_reg <= `PLSL_RST_LDO;
         timer_reg <= `PLSL_RST_BYTE;
         comm <= `PLSL_RST_COMM;
         dev_flags <= `PLSL_RST_BYTE;
         dev_mask <= `PLSL_RST_BYTE;
         link_flags <= `PLSL_RST_BYTE;
         link_mask <= `PLSL_RST_BYTE;
         tx_data <= '{default: `PLSL_RST_BYTE};
         rx_data <= '{default: `PLSL_RST_BYTE};
         rx_buf <= '{default: `PLSL_RST_BYTE};
         rx_cnt <= 3'd0;
         rx_seen <= 1'b0;
         tx_idx <= 2'd0;
         tx_valid <= 1'b0;
         tx_last <= 1'b0;
         tx_byte <= `PLSL_RST_BYTE;
         blank_cnt <= 16'd0;
         chg_cnt <= 32'd0;
         chg_stat <= `PLSL_CHG_STAT_OFF;
         reg_rdata <= `PLSL_RST_BYTE;
         int_n <= 1'b1;
         pullup_on <= 1'b0;
         switch_closed <= 1'b0;
         link_enabled <= 1'b0;
         ldo_bypass <= 1'b0;
         ldo_fixed <= 1'b0;
         ldo_offset <= 3'd0;
         ldo_min <= 3'd0;
      end else begin
         state <= next_state;
         enable_bit <= next_enable_bit;
         ldo_reg <= next_ldo_reg;
         timer_reg <= next_timer_reg;
         comm <= next_comm;
         dev_flags <= next_dev_flags;
         dev_mask <= next_dev_mask;
         link_flags <= next_link_flags;
         link_mask <= next_link_mask;
         tx_data <= next_tx_data;
         rx_data <= next_rx_data;
         rx_buf <= next_rx_buf;
         rx_cnt <= next_rx_cnt;
         rx_seen <= next_rx_seen;
         tx_idx <= next_tx_idx;
         tx_valid <= next_tx_valid;
         tx_last <= next_tx_last;
         tx_byte <= next_tx_byte;
         blank_cnt <= next_blank_cnt;
         chg_cnt <= next_chg_cnt;
         chg_stat <= next_chg_stat;
         reg_rdata <= next_reg_rdata;
         int_n <= next_int_n;
         pullup_on <= next_pullup_on;
         switch_closed <= next_switch_closed;
         link_enabled <= next_link_enabled;
         // Regulator mode, slave role only: zero offset bypasses, else range bit picks
         ldo_bypass <= !is_master && ldo_reg[4:2] == 3'd0;
         ldo_fixed <= !is_master && ldo_reg[4:2] != 3'd0 &&
                      timer_reg[`PLSL_BIT_RANGE];
         ldo_offset <= ldo_reg[4:2];
         ldo_min <= ldo_reg[7:5];
      end
   end

   // ==========================================
   // Checks
   sequence s_last_sent;
      tx_valid && tx_last && tx_ready;
   endsequence

   property p_hold_off;
      @(posedge sys_clk) disable iff (srst) disabled |=> state == PLSL_SHUTDOWN;
   endproperty
   a_hold_off: assert property (p_hold_off) else $error("left shutdown while disabled");

   property p_wake;
      @(posedge sys_clk) disable iff (srst)
         state == PLSL_SHUTDOWN && !disabled |=> state == PLSL_DETECT;
   endproperty
   a_wake: assert property (p_wake) else $error("enable did not start detection");

   property p_state_flag;
      @(posedge sys_clk) disable iff (srst)
         state != $past(state) |-> dev_flags[`PLSL_BIT_STATE_CHG];
   endproperty
   a_state_flag: assert property (p_state_flag) else $error("state change not flagged");

   property p_rx_det;
      @(posedge sys_clk) disable iff (srst)
         link_enabled && rx_start |=> link_flags[`PLSL_BIT_RX_DET];
   endproperty
   a_rx_det: assert property (p_rx_det) else $error("receive detect flag missing");

   property p_rx_err_keep;
      @(posedge sys_clk) disable iff (srst)
         link_enabled && rx_end && rx_error |=> link_flags[`PLSL_BIT_RX_ERR] &&
                                               rx_data[0] == $past(rx_data[0]) &&
                                               rx_data[1] == $past(rx_data[1]) &&
                                               rx_data[2] == $past(rx_data[2]);
   endproperty
   a_rx_err_keep: assert property (p_rx_err_keep) else $error("bad packet changed data");

   property p_force_idle;
      @(posedge sys_clk) disable iff (srst)
         state == PLSL_FOUND && !is_master && !disabled && reg_wr &&
         reg_addr == `PLSL_OFS_ACTION && reg_wdata == 8'h08 |=> state == PLSL_IDLE;
   endproperty
   a_force_idle: assert property (p_force_idle) else $error("force idle ignored");

   property p_csum;
      @(posedge sys_clk) disable iff (srst)
         tx_valid && tx_last |->
            tx_byte == plsl_csum(tx_data[0], tx_data[1], tx_data[2], comm[1:0]);
   endproperty
   a_csum: assert property (p_csum) else $error("checksum byte wrong");

   property p_tx_done;
      @(posedge sys_clk) disable iff (srst)
         s_last_sent |=> !tx_valid && link_flags[`PLSL_BIT_TX_OK] && comm[1:0] == 2'b00;
   endproperty
   a_tx_done: assert property (p_tx_done) else $error("send did not finish");

   property p_thermal;
      @(posedge sys_clk) disable iff (srst)
         hot_s |=> !switch_closed;
   endproperty
   a_thermal: assert property (p_thermal) else $error("switch closed while hot");

   property p_int_cause;
      @(posedge sys_clk) disable iff (srst)
         !int_n |-> (|dev_flags) || (|link_live);
   endproperty
   a_int_cause: assert property (p_int_cause) else $error("interrupt with no flag");

   property p_summary;
      @(posedge sys_clk) disable iff (srst)
         |link_flags |-> dev_flags[`PLSL_BIT_SUMMARY];
   endproperty
   a_summary: assert property (p_summary) else $error("summary flag missing");
endmodule : plsl_link_ctrl

/* plsl_master_model.sv */
// Line master model: opens every exchange and takes the slave's answers
`timescale 1ns/100ps
module plsl_master_model (
   input wire logic sys_clk,
   input wire logic slow,
   input wire logic tx_valid,
   input wire logic [7:0] tx_byte,
   input wire logic tx_last,
   output logic tx_ready = 1'b0,
   output logic rx_start = 1'b0,
   output logic rx_valid = 1'b0,
   output logic rx_end = 1'b0,
   output logic rx_error = 1'b0,
   output logic [7:0] rx_byte = 8'h00
);
   logic [8:0] got[$];
   // Slow mode stalls every other cycle so held offers get exercised
   always @(negedge sys_clk) tx_ready <= slow ? ~tx_ready : 1'b1;
   always @(posedge sys_clk) if (tx_valid && tx_ready) got.push_back({tx_last, tx_byte});
   // Start pulse, bytes with checksum last, end pulse carrying the error mark
   task automatic send(input logic [31:0] pk, input int n, input logic err);
      @(negedge sys_clk);
      rx_start = 1'b1;
      for (int i = 0; i < n; i++) begin
         @(negedge sys_clk);
         {rx_start, rx_valid, rx_byte} = {2'b01, pk[8*i+:8]};
      end
      @(negedge sys_clk);
      {rx_valid, rx_end, rx_error, rx_byte} = {2'b01, err, ~rx_byte}; // No stale byte
      @(negedge sys_clk);
      {rx_end, rx_error} = 2'b00;
   endtask : send
endmodule : plsl_master_model

/* plsl_link_ctrl_tb_top.sv */
// Self-checking bench of the link control block in slave and master roles
`timescale 1ns/100ps
module plsl_link_ctrl_tb_top;
   logic sys_clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, en_n = 1, above = 0, hot = 0, slow = 0;
   logic mst = 0, below = 0;
   logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, tx_byte, rx_byte;
   logic rx_start, rx_valid, rx_end, rx_error, tx_valid, tx_last, tx_ready, int_n;
   logic sw, le, pu, byp, fix;
   logic [2:0] ldo_offset, ldo_min;
   int err_total = 0, total_checks = 0, cyc = 0;
   plsl_link_ctrl #(.CHG_UNIT_CYCLES(20)) dut (.sys_clk, .srst, .reg_addr, .reg_wr, .reg_rd,
      .reg_wdata, .reg_rdata, .enable_pin_n(en_n), .line_below_short(below),
      .line_above_detect(above), .thermal_hot(hot), .role_master_pin(mst),
      .slave_address_pin(1'b1), .rx_start, .rx_valid, .rx_byte, .rx_end, .rx_error,
      .tx_valid, .tx_byte, .tx_last, .tx_ready, .int_n, .pullup_on(pu), .switch_closed(sw),
      .link_enabled(le), .ldo_bypass(byp), .ldo_fixed(fix), .ldo_offset, .ldo_min);
   plsl_master_model pm (.sys_clk, .slow, .tx_valid, .tx_byte, .tx_last, .tx_ready,
      .rx_start, .rx_valid, .rx_end, .rx_error, .rx_byte);
   initial forever #2.5 sys_clk = ~sys_clk;
   // Hang guard: the run needs a few thousand cycles
   always @(posedge sys_clk) if (++cyc == 20000) begin
      err_total++;
      report_and_stop();
   end
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : report_and_stop
   task automatic chk(input string nm, input logic [8:0] g, e);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // One register cycle; reads compare the masked answer with d
   task automatic io(input logic [7:0] a, d, m, input logic w);
      @(negedge sys_clk);
      {reg_addr, reg_wdata, reg_wr, reg_rd} = {a, d, w, !w};
      @(negedge sys_clk);
      {reg_wr, reg_rd} = 2'b00;
      if (!w) chk($sformatf("reg %h", a), reg_rdata & m, d);
   endtask : io
   task automatic t_link();
      io(8'h05, 8'h01, 8'h1d, 0);
      chk("address", reg_rdata[0], 1'b1);
      io(8'h08, 8'h09, 0, 1);
      io(8'h01, 8'h01, 0, 1);
      repeat (2) @(negedge sys_clk);
      io(8'h05, 8'h05, 8'h1d, 0);
      chk("int_n", int_n, 0);
      io(8'h07, 8'h01, 8'hff, 0);
      io(8'h0c, 8'hff, 0, 1);
      chk("int_n", int_n, 1);
      above = 1;
      repeat (5) @(negedge sys_clk);
      io(8'h05, 8'h09, 8'h1d, 0);
      chk("link", le, 1'b1);
      io(8'h07, 8'h01, 8'hff, 0);
      pm.send(32'h0046_3412, 3, 0);
      @(negedge sys_clk);
      chk("int_n", int_n, 0);
      io(8'h07, 8'h08, 8'hff, 0);
      io(8'h0b, 8'h07, 8'hff, 0);
      io(8'h10, 8'h12, 8'hff, 0);
      io(8'h11, 8'h34, 8'hff, 0);
      io(8'h12, 8'h00, 8'hff, 0);
      // Bad checksum, then a good sum with the error mark
      for (int i = 0; i < 2; i++) begin
         pm.send(i ? 32'h00ee_7777 : 32'h0055_7777, 3, i[0]);
         io(8'h0b, 8'h09, 8'hff, 0);
         io(8'h10, 8'h12, 8'hff, 0);
      end
      $display("link test done");
   endtask : t_link
   task automatic t_tx();
      logic [7:0] s;
      s = 8'h00;
      slow = 1;
      io(8'h0d, 8'ha1, 0, 1);
      io(8'h0e, 8'hb2, 0, 1);
      io(8'h0f, 8'hc3, 0, 1);
      for (int n = 1; n < 4; n++) begin
         pm.send(32'h0000_0505, 2, 0);
         io(8'h0b, 8'h05, 8'hff, 0);
         pm.got.delete();
         io(8'h09, 8'h10 + 8'(n), 0, 1);
         s += n == 1 ? 8'ha1 : n == 2 ? 8'hb2 : 8'hc3;
         for (int k = 0; k < 20 && tx_valid; k++) @(negedge sys_clk);
         chk("count", 9'(pm.got.size()), 9'(n + 1));
         chk("first", pm.got[0], 9'h0a1);
         chk("sum", pm.got[n], {1'b1, s});
         io(8'h0b, 8'h20, 8'hff, 0);
      end
      // No fresh packet, so an answer is refused
      io(8'h09, 8'h11, 0, 1);
      io(8'h0b, 8'h40, 8'hff, 0);
      chk("quiet", tx_valid, 0);
      slow = 0;
      $display("transmit test done");
   endtask : t_tx
   task automatic t_misc();
      io(8'h04, 8'h08, 0, 1);
      repeat (2) @(negedge sys_clk);
      io(8'h05, 8'h15, 8'h1d, 0);
      io(8'h07, 8'h01, 8'hff, 0);
      hot = 1;
      repeat (5) @(negedge sys_clk);
      io(8'h07, 8'h20, 8'hff, 0);
      io(8'h05, 8'h15, 8'h1d, 0);
      io(8'h02, 8'ha0, 0, 1);
      io(8'h03, 8'h01, 0, 1);
      chk("bypass", {byp, fix}, 2'b10);
      io(8'h02, 8'ha8, 0, 1);
      @(negedge sys_clk);
      chk("fixed", {byp, fix, ldo_min, ldo_offset}, 8'h6a);
      io(8'h01, 8'h00, 0, 1);
      repeat (2) @(negedge sys_clk);
      io(8'h05, 8'h01, 8'h1d, 0);
      $display("misc test done");
   endtask : t_misc
   // Master role after a mid-run reset: charge, thermal, blanking expiry, restart
   task automatic t_master();
      @(negedge sys_clk);
      {srst, mst, hot, below, above} = 5'b11000;
      repeat (5) @(negedge sys_clk);
      srst = 0;
      io(8'h01, 8'h01, 0, 1);
      repeat (2) @(negedge sys_clk);
      chk("pullup", {pu, sw}, 2'b10);
      below = 1;
      repeat (4) @(negedge sys_clk);
      chk("charge", {pu, sw}, 2'b01);
      hot = 1;
      repeat (3) @(negedge sys_clk);
      chk("hot", sw, 1'b0);
      hot = 0;
      io(8'h05, 8'h48, 8'hdc, 0);
      below = 0;
      repeat (2000) @(negedge sys_clk);
      io(8'h05, 8'h90, 8'hdc, 0);
      chk("safe", sw, 1'b0);
      io(8'h04, 8'h04, 0, 1);
      @(negedge sys_clk);
      io(8'h05, 8'h04, 8'hdc, 0);
      $display("master test done");
   endtask : t_master
   initial begin
      repeat (5) @(negedge sys_clk);
      srst = 0;
      t_link();
      t_tx();
      t_misc();
      t_master();
      report_and_stop();
   end
endmodule : plsl_link_ctrl_tb_top
